// ===== design/ffc_flag_fifo.sv
// fifo storage with almost-full / almost-empty flags, clear and guarded reads
// assumes one clock, synchronous active-low reset, user logic on both sides
`include "ffc_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// small input buffer with valid/ready on both sides
module ffc_skid_fifo #(
	parameter int WIDTH = 8,                  // word width
	parameter int DEPTH = `FFC_BUF_DEPTH      // words held
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             flush,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;   // pointer width
	localparam int CW = $clog2(DEPTH + 1);                 // count width

	logic [WIDTH-1:0] mem [DEPTH];         // buffer words
	logic [PW-1:0]    wrPtr_reg;           // next slot to fill
	logic [PW-1:0]    rdPtr_reg;           // next slot to drain
	logic [CW-1:0]    count_reg;           // words held
	logic             pushFire;            // word accepted
	logic             popFire;             // word handed on

	// honest full and empty
	assign inReady  = (count_reg != CW'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData  = mem[rdPtr_reg];
	assign pushFire = inValid && inReady && !flush;
	assign popFire  = outValid && outReady && !flush;

	// storage write
	always_ff @(posedge clock)
	begin
		if (pushFire)
			mem[wrPtr_reg] <= inData;
	end

	// pointers and count, flush empties the buffer
	always_ff @(posedge clock)
	begin
		if (!rst_n || flush)
		begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (pushFire)
				wrPtr_reg <= (wrPtr_reg == PW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
			if (popFire)
				rdPtr_reg <= (rdPtr_reg == PW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
			count_reg <= count_reg + CW'(pushFire) - CW'(popFire);
		end
	end
endmodule // ffc_skid_fifo

////////////////////////////////////////////////////////////////////////////////
// main fifo with threshold flags
module ffc_flag_fifo #(
	parameter int WIDTH       = 8,        // word width
	parameter int DEPTH       = 4096,     // words of main storage, at most 65535
	parameter int BLOCKS_DEEP = 1         // stacked blocks in depth: 1,2,4,8,16
) (
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire logic                 fifoClear,
	input  wire ffc_pkg::ffc_thresh_t upperThreshold,
	input  wire ffc_pkg::ffc_thresh_t lowerThreshold,
	input  wire logic                 writeValid,
	output logic                      writeReady,
	input  wire logic [WIDTH-1:0]     writeData,
	input  wire logic                 readRequest,
	output logic                      readValid,
	output logic      [WIDTH-1:0]     readData,
	output logic                      fullFlag,
	output logic                      emptyFlag,
	output logic                      nearlyFullOutput,
	output logic                      nearlyEmptyOutput,
	output ffc_pkg::ffc_level_t       fillLevel
);
	import ffc_pkg::*;

	localparam int PW       = (DEPTH > 1) ? $clog2(DEPTH) : 1;      // pointer width
	localparam int THR_BITS = `FFC_THR_BASE + $clog2(BLOCKS_DEEP);  // meaningful bits
	localparam ffc_thresh_t THR_MASK = ffc_thresh_t'((1 << THR_BITS) - 1);

	// keeps only the threshold bits the arrangement provides
	function automatic ffc_thresh_t activeThr(input ffc_thresh_t raw);
		activeThr = raw & THR_MASK;
	endfunction

	logic [WIDTH-1:0] mem [DEPTH];        // main storage
	logic [PW-1:0]    wrPtr_reg;          // next write slot
	logic [PW-1:0]    rdPtr_reg;          // next read slot
	ffc_level_t       level_reg;          // words written and not read
	ffc_level_t       level_next;         // level after this edge
	logic             readValid_reg;      // data strobe
	logic [WIDTH-1:0] readData_reg;       // data held for user
	logic             bufValid;           // buffer has a word
	logic [WIDTH-1:0] bufData;            // buffer head word
	logic             wrFire;             // word enters storage
	logic             rdFire;             // word leaves storage
	ffc_thresh_t      upperUsed;          // masked upper threshold
	ffc_thresh_t      lowerUsed;          // masked lower threshold
	ffc_level_t       upperLevel;         // upper threshold in words
	ffc_level_t       lowerLevel;         // lower threshold in words
	logic [WIDTH-1:0] headWord;           // word a read would return

	////////////////////////////////////////////////////////////////////////////
	// input buffer; stalls when main storage is full
	ffc_skid_fifo #(
		.WIDTH (WIDTH),
		.DEPTH (`FFC_BUF_DEPTH)
	) inBuf (
		.clock    (clock),
		.rst_n    (rst_n),
		.flush    (fifoClear),
		.inValid  (writeValid),
		.inReady  (writeReady),
		.inData   (writeData),
		.outValid (bufValid),
		.outReady (!fullFlag),
		.outData  (bufData)
	);

	////////////////////////////////////////////////////////////////////////////
	// flag decode
	assign upperUsed  = activeThr(upperThreshold);
	assign lowerUsed  = activeThr(lowerThreshold);
	assign upperLevel = {upperUsed, `FFC_THR_SHIFT'h00};
	assign lowerLevel = {lowerUsed, `FFC_THR_SHIFT'h00};
	assign nearlyFullOutput  = (level_reg >= upperLevel);
	assign nearlyEmptyOutput = (lowerLevel >= level_reg);
	assign emptyFlag  = (level_reg == `FFC_LEVEL_RST);
	assign fullFlag   = (level_reg == ffc_level_t'(DEPTH));
	assign fillLevel  = level_reg;
	assign headWord   = mem[rdPtr_reg];

	// transfers; clear overrides both
	assign wrFire = bufValid && !fullFlag && !fifoClear;
	assign rdFire = readRequest && !emptyFlag && !fifoClear;
	assign level_next = fifoClear ? `FFC_LEVEL_RST
		: level_reg + ffc_level_t'(wrFire) - ffc_level_t'(rdFire);
	assign readValid = readValid_reg;
	assign readData  = readData_reg;

	////////////////////////////////////////////////////////////////////////////
	// storage write
	always_ff @(posedge clock)
	begin
		if (wrFire)
			mem[wrPtr_reg] <= bufData;
	end

	// pointers and level
	always_ff @(posedge clock)
	begin
		if (!rst_n || fifoClear)
		begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			level_reg <= `FFC_LEVEL_RST;
		end
		else
		begin
			if (wrFire)
				wrPtr_reg <= (wrPtr_reg == PW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
			if (rdFire)
				rdPtr_reg <= (rdPtr_reg == PW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
			level_reg <= level_next;
		end
	end

	// read data register, empty-guarded
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			readValid_reg <= 1'b0;
			readData_reg  <= '0;
		end
		else
		begin
			readValid_reg <= rdFire;
			if (rdFire)
				readData_reg <= headWord;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence readTaken;
		readRequest && !emptyFlag && !fifoClear;
	endsequence

	sequence wordOut(logic [WIDTH-1:0] w);
		readValid && (readData == w);
	endsequence

	a_read_returns_head: assert property (
		readTaken |=> wordOut($past(headWord)))
		else $error("read did not return the head word");

	a_no_read_empty: assert property (
		(emptyFlag || fifoClear) |=> !readValid)
		else $error("read happened while empty");

	a_clear_to_empty: assert property (
		fifoClear |=> emptyFlag && !fullFlag && nearlyEmptyOutput
			&& (!nearlyFullOutput || (upperUsed == '0)))
		else $error("clear did not force the empty state");

	a_level_counts: assert property (
		!fifoClear |=> level_reg == $past(level_reg) + ffc_level_t'($past(wrFire))
			- ffc_level_t'($past(rdFire)))
		else $error("fill level does not track transfers");

	a_full_upper: assert property (
		nearlyFullOutput |-> level_reg[`FFC_LEVEL_W-1:`FFC_THR_SHIFT] >= upperUsed)
		else $error("almost-full set below the upper threshold");

	a_empty_lower: assert property (
		!nearlyEmptyOutput |-> level_reg > {lowerUsed, `FFC_THR_SHIFT'h00})
		else $error("almost-empty clear at or below the lower threshold");

	a_thr_width: assert property (
		((upperThreshold & THR_MASK) == '0) |-> nearlyFullOutput)
		else $error("threshold bits beyond the arrangement were used");
endmodule // ffc_flag_fifo

// ===== design/ffc_defs.svh
// constants for the fifo flag and clear logic
// assumes inclusion by every design file that needs widths or reset values
`ifndef FFC_DEFS_SVH
`define FFC_DEFS_SVH

`define FFC_LEVEL_W   16          // fill level width
`define FFC_THR_W     8           // threshold field width
`define FFC_THR_SHIFT 8           // zero bits appended below a threshold
`define FFC_THR_BASE  4           // threshold bits of a depth-one stack
`define FFC_LEVEL_RST 16'h0000    // fill level after reset or clear
`define FFC_BUF_DEPTH 4           // words in the input buffer

`endif

// ===== design/ffc_pkg.sv
// types shared by the fifo flag and clear logic
// assumes ffc_defs.svh is on the include path
`include "ffc_defs.svh"

package ffc_pkg;
	typedef logic [`FFC_LEVEL_W-1:0] ffc_level_t;   // words held
	typedef logic [`FFC_THR_W-1:0]   ffc_thresh_t;  // threshold field
endpackage

// ===== bench/ffc_user_model.sv
// user logic on the write and read sides of the flag fifo
// assumes the bench moves pushLimit and popOn shortly after a rising edge
module ffc_user_model (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic [31:0] pushLimit,
	input  wire logic       popOn,
	input  wire logic       writeReady,
	output logic            writeValid,
	output logic [7:0]      writeData,
	output logic            readRequest,
	output int              pushCount
);
	timeunit 1ns;
	timeprecision 100ps;
	int nextCount;  // words taken after this edge
	assign nextCount = pushCount + ((writeValid && writeReady) ? 1 : 0);
	// offer stays up until taken; idle data shows the inverse pattern
	// outputs settle at the first edge, which falls inside reset
	always @(posedge clock)
	begin
		pushCount <= rst_n ? nextCount : 0;
		writeValid <= #1 rst_n && (nextCount < pushLimit);
		writeData <= #1 (nextCount < pushLimit) ? nextCount[7:0] : ~nextCount[7:0];
		readRequest <= #1 popOn;
	end
endmodule // ffc_user_model

// ===== bench/tb_top.sv
// self-checking bench for the flag fifo
// assumes the design files and ffc_defs.svh are on the include path
`include "ffc_defs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import ffc_pkg::*;
	localparam int DEPTH = 512;             // small main storage
	localparam int BUF   = `FFC_BUF_DEPTH;  // input buffer words
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        fifoClear = 1'b0;
	logic        popOn = 1'b0;
	ffc_thresh_t upperThreshold = 8'h11;    // masked to 1
	ffc_thresh_t lowerThreshold = 8'hF1;    // masked to 1
	int          pushLimit = 0;
	int          pushCount;
	int          mismatches = 0;
	int          comparisons = 0;
	logic        writeValid, writeReady, readRequest, readValid;
	logic        fullFlag, emptyFlag, nearlyFullOutput, nearlyEmptyOutput;
	logic [7:0]  writeData, readData;
	ffc_level_t  fillLevel;
	always #2 clock = ~clock;
	ffc_flag_fifo #(.WIDTH(8), .DEPTH(DEPTH), .BLOCKS_DEEP(1)) dut_u (.clock(clock),
		.rst_n(rst_n), .fifoClear(fifoClear), .upperThreshold(upperThreshold),
		.lowerThreshold(lowerThreshold), .writeValid(writeValid), .writeReady(writeReady),
		.writeData(writeData), .readRequest(readRequest), .readValid(readValid),
		.readData(readData), .fullFlag(fullFlag), .emptyFlag(emptyFlag),
		.nearlyFullOutput(nearlyFullOutput), .nearlyEmptyOutput(nearlyEmptyOutput),
		.fillLevel(fillLevel));
	ffc_user_model user_u (.clock(clock), .rst_n(rst_n), .pushLimit(pushLimit),
		.popOn(popOn), .writeReady(writeReady), .writeValid(writeValid),
		.writeData(writeData), .readRequest(readRequest), .pushCount(pushCount));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// inputs move 1 ns after the edge, outputs are read there too
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wait_level(input int n);
		int i;
		for (i = 0; i < 3000 && fillLevel !== 16'(n); i++)
			step(1);
		if (i == 3000)
		begin
			chk("level wait", 16'(n), fillLevel);
			close_out();
		end
	endtask
	// empty state: level and all four flags
	task automatic chk_empty();
		chk("fillLevel", 16'h0000, fillLevel);
		chk("emptyFlag", 16'h0001, {15'h0000, emptyFlag});
		chk("fullFlag", 16'h0000, {15'h0000, fullFlag});
		chk("nearlyEmpty", 16'h0001, {15'h0000, nearlyEmptyOutput});
		chk("nearlyFull", 16'h0000, {15'h0000, nearlyFullOutput});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// reads while empty are ignored
	task automatic t_empty_read();
		popOn = 1'b1;
		repeat (4)
		begin
			step(1);
			chk("readValid", 16'h0000, {15'h0000, readValid});
		end
		popOn = 1'b0;
		step(1);
	endtask
	// flags around one threshold unit of 256 words
	task automatic t_thresholds();
		int lv[3] = '{255, 256, 257};
		logic af[3] = '{1'b0, 1'b1, 1'b1};
		logic ae[3] = '{1'b1, 1'b1, 1'b0};
		for (int k = 0; k < 3; k++)
		begin
			pushLimit = lv[k];
			wait_level(lv[k]);
			step(3);
			chk("fillLevel", 16'(lv[k]), fillLevel);
			chk("nearlyFull", {15'h0000, af[k]}, {15'h0000, nearlyFullOutput});
			chk("nearlyEmpty", {15'h0000, ae[k]}, {15'h0000, nearlyEmptyOutput});
		end
	endtask
	// fill until refused, then drain in order while the refused word goes in
	task automatic t_full_drain();
		int idx = 0;
		pushLimit = DEPTH + BUF + 1;
		wait_level(DEPTH);
		step(BUF + 4);
		chk("fullFlag", 16'h0001, {15'h0000, fullFlag});
		chk("writeReady", 16'h0000, {15'h0000, writeReady});
		chk("pushCount", 16'(DEPTH + BUF), 16'(pushCount));
		popOn = 1'b1;
		for (int i = 0; i < 3000 && idx < DEPTH + BUF + 1; i++)
		begin
			step(1);
			if (readValid === 1'b1)
			begin
				chk("readData", 16'(idx[7:0]), {8'h00, readData});
				idx++;
			end
		end
		popOn = 1'b0;
		step(4);
		chk("pops", 16'(DEPTH + BUF + 1), 16'(idx));
		chk_empty();
	endtask
	// clear in mid-fill returns to empty
	task automatic t_clear();
		pushLimit = pushCount + 10;
		wait_level(10);
		step(2);
		fifoClear = 1'b1;
		step(1);
		fifoClear = 1'b0;
		chk_empty();
	endtask
	initial
	begin
		step(2);
		rst_n = 1'b1;
		step(1);
		chk_empty();
		t_empty_read();
		t_thresholds();
		t_full_drain();
		t_clear();
		close_out();
	end
endmodule // tb_top
